// *** src/hwbo_pkg.sv ***
/*
 * Package for the host window bank offset block: register indices, field
 * positions, reset values and mode enumerations.
 * Assumes a byte-wide indexed register port sitting beside the host bus.
 */
package hwbo_pkg;
	// ------------------------------------------------------------
	// register indices
	// ------------------------------------------------------------
	localparam logic [7:0] HWBO_IDX_SET_RESET = 8'h00;
	localparam logic [7:0] HWBO_IDX_SR_ENABLE = 8'h01;
	localparam logic [7:0] HWBO_IDX_OFS_FIRST = 8'h09;
	localparam logic [7:0] HWBO_IDX_OFS_SECOND = 8'h0A;
	localparam logic [7:0] HWBO_IDX_WR_EXT = 8'h0B;
	// ------------------------------------------------------------
	// reset values and write extension used-bit mask
	// ------------------------------------------------------------
	localparam logic [7:0] HWBO_RST_OFS = 8'h00;
	localparam logic [7:0] HWBO_RST_WR_EXT = 8'h00;
	localparam logic [7:0] HWBO_RST_SR = 8'h00;
	localparam logic [7:0] HWBO_WR_EXT_USED = 8'h3F;
	// ------------------------------------------------------------
	// write mode extension field positions
	// ------------------------------------------------------------
	localparam int HWBO_B_SECOND_EN = 0;
	localparam int HWBO_B_BY8 = 1;
	localparam int HWBO_B_EXT_WR = 2;
	localparam int HWBO_B_LATCH8 = 3;
	localparam int HWBO_B_ENH16 = 4;
	localparam int HWBO_B_GRAN16 = 5;
	// memory map select code meaning the 64K window
	localparam logic [1:0] HWBO_MAP_64K = 2'h1;
	// ------------------------------------------------------------
	// widths and multiplicities
	// ------------------------------------------------------------
	localparam int HWBO_HA_W = 17;
	localparam int HWBO_MA_W = 22;
	localparam int HWBO_BY8_SHIFT = 3;
	localparam int HWBO_SIXTEEN_BYTE_BLOCK_ADDRESSING_SHIFT = 4;
	localparam logic [4:0] HWBO_BYTES_NORMAL = 5'h01;
	localparam logic [4:0] HWBO_BYTES_EXT = 5'h08;
	localparam logic [4:0] HWBO_BYTES_ENH = 5'h10;
	localparam logic [3:0] HWBO_LATCH_NORMAL = 4'h4;
	localparam logic [3:0] HWBO_LATCH_WIDE = 4'h8;
	localparam logic [2:0] HWBO_WMODE_4 = 3'h4;
	localparam logic [2:0] HWBO_WMODE_5 = 3'h5;

	typedef enum logic [1:0] {
		HWBO_ADDR_PACKED = 2'b00,
		HWBO_ADDR_BY8 = 2'b01,
		HWBO_ADDR_SIXTEEN_BYTE_BLOCK_ADDRESSING = 2'b11
	} hwbo_addr_mode_t;
endpackage

// *** src/hwbo_addr_sum.sv ***
/*
 * Address summer: masks host bit 16 in the 64K map or with the second window enabled (bit 15 with the second window only), adds the selected offset at 4K
 * or 16K weight and drops the carry.
 * Assumes the caller supplies a stable offset selection and mode bits.
 */
`timescale 1ns/1ps
`default_nettype none
module hwbo_addr_sum
	import hwbo_pkg::*;
(
	// host address and selection
	input wire logic [HWBO_HA_W-1:0] host_addr,
	input wire logic [7:0] offset,
	input wire logic map_64k,
	input wire logic second_en,
	input wire logic gran16,
	// result
	output logic [HWBO_MA_W-1:0] sum_addr
);
	logic [HWBO_HA_W-1:0] masked_host_address;
	logic [9:0] base_hi;
	logic [9:0] ofs_hi;
	logic [9:0] page_sum;

	always_comb
	begin
		masked_host_address = host_addr;
		if (map_64k || second_en)
		begin
			masked_host_address[16] = 1'b0;
		end
		if (map_64k || second_en)
		begin
			masked_host_address[15] = 1'b0;
		end
		if (map_64k && !second_en)
		begin
			masked_host_address[15] = host_addr[15];
		end
	end

	always_comb
	begin
		base_hi = {5'h00, masked_host_address[16:12]};
		if (gran16)
		begin
			ofs_hi = {offset, 2'b00};
		end
		else
		begin
			ofs_hi = {2'b00, offset};
		end
		// carry out of bit 21 is dropped by the width
		page_sum = base_hi + ofs_hi;
		if (!gran16)
		begin
			page_sum[9:8] = 2'b00;
		end
	end

	assign sum_addr = {page_sum, masked_host_address[11:0]};
endmodule
`default_nettype wire

// *** src/hwbo_top.sv ***
/*
 * Host window bank offset: maps host cycles in the legacy window onto the
 * display memory address, holds offset and write mode extension registers.
 * Assumes an indexed byte register port on sys_clk and host cycles given
 * as a one-cycle strobe with address; the far memory path takes the result.
 */
`timescale 1ns/1ps
`default_nettype none
module hwbo_top
	import hwbo_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// indexed register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_index,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// neighbouring mode inputs
	input wire logic [1:0] memory_map_select,
	input wire logic extended_sequencer_mode,
	input wire logic [2:0] write_mode_sel,
	input wire logic [7:0] plane_write_mask,
	// host cycle
	input wire logic host_stb,
	input wire logic [HWBO_HA_W-1:0] host_addr,
	// display memory address path
	output logic mem_stb,
	output logic [HWBO_MA_W-1:0] summed_memory_address,
	output logic [HWBO_MA_W-1:0] block_address,
	output logic [15:0] byte_write_mask,
	// mode outputs for the write datapath
	output logic [4:0] bytes_per_host_byte,
	output logic [3:0] latch_bytes,
	output logic color_ext_enable,
	output logic enh_mode_active,
	output logic page_select_used,
	output logic [7:0] set_reset_value,
	output logic [7:0] set_reset_enable
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] bank_offset_first;
	logic [7:0] bank_offset_second;
	logic [7:0] write_mode_extensions;
	logic ext_wr_q;
	logic sel_second;
	logic [7:0] offset_sel;
	logic [HWBO_MA_W-1:0] next_sum;
	logic enh16;
	logic sixteen_byte_block_addressing;
	logic eight_byte_block_addressing;
	hwbo_addr_mode_t addr_mode;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			bank_offset_first <= HWBO_RST_OFS;
			bank_offset_second <= HWBO_RST_OFS;
			write_mode_extensions <= HWBO_RST_WR_EXT;
		end
		else if (reg_wr)
		begin
			if (reg_index == HWBO_IDX_OFS_FIRST)
				bank_offset_first <= reg_wdata;
			else if (reg_index == HWBO_IDX_OFS_SECOND)
				bank_offset_second <= reg_wdata;
			else if (reg_index == HWBO_IDX_WR_EXT)
				write_mode_extensions <= reg_wdata & HWBO_WR_EXT_USED;
		end
	end

	// set/reset registers: upper nibble cleared when extended writes turn off
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			set_reset_value <= HWBO_RST_SR;
			set_reset_enable <= HWBO_RST_SR;
			ext_wr_q <= 1'b0;
		end
		else
		begin
			ext_wr_q <= write_mode_extensions[HWBO_B_EXT_WR];
			if (reg_wr && reg_index == HWBO_IDX_SET_RESET)
				set_reset_value <= reg_wdata;
			else if (ext_wr_q && !write_mode_extensions[HWBO_B_EXT_WR])
				set_reset_value[7:4] <= 4'h0;
			if (reg_wr && reg_index == HWBO_IDX_SR_ENABLE)
				set_reset_enable <= reg_wdata;
			else if (ext_wr_q && !write_mode_extensions[HWBO_B_EXT_WR])
				set_reset_enable[7:4] <= 4'h0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			if (reg_index == HWBO_IDX_OFS_FIRST)
				reg_rdata <= bank_offset_first;
			else if (reg_index == HWBO_IDX_OFS_SECOND)
				reg_rdata <= bank_offset_second;
			else if (reg_index == HWBO_IDX_WR_EXT)
				reg_rdata <= write_mode_extensions;
			else if (reg_index == HWBO_IDX_SET_RESET)
				reg_rdata <= set_reset_value;
			else if (reg_index == HWBO_IDX_SR_ENABLE)
				reg_rdata <= set_reset_enable;
			else
				reg_rdata <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// offset selection and summing
	// ------------------------------------------------------------
	// the second window is the upper 32K half of the host range
	assign sel_second = write_mode_extensions[HWBO_B_SECOND_EN]
		&& host_addr[15];
	assign offset_sel = sel_second ? bank_offset_second
		: bank_offset_first;

	hwbo_addr_sum u_sum (
		.host_addr(host_addr),
		.offset(offset_sel),
		.map_64k(memory_map_select == HWBO_MAP_64K),
		.second_en(write_mode_extensions[HWBO_B_SECOND_EN]),
		.gran16(write_mode_extensions[HWBO_B_GRAN16]),
		.sum_addr(next_sum)
	);

	// page select only matters at 4K granularity
	assign page_select_used = extended_sequencer_mode
		&& !write_mode_extensions[HWBO_B_GRAN16];

	// ------------------------------------------------------------
	// write mode extensions
	// ------------------------------------------------------------
	assign enh16 = write_mode_extensions[HWBO_B_ENH16]
		&& write_mode_extensions[HWBO_B_EXT_WR];
	assign sixteen_byte_block_addressing = enh16;
	// with both set, sixteen_byte_block_addressing takes priority; software must avoid it
	assign eight_byte_block_addressing = write_mode_extensions[HWBO_B_BY8]
		&& !enh16;
	assign addr_mode = sixteen_byte_block_addressing ? HWBO_ADDR_SIXTEEN_BYTE_BLOCK_ADDRESSING
		: (eight_byte_block_addressing ? HWBO_ADDR_BY8
		: HWBO_ADDR_PACKED);
	assign enh_mode_active = enh16 && (write_mode_sel == HWBO_WMODE_4
		|| write_mode_sel == HWBO_WMODE_5);
	assign color_ext_enable = enh16;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			mem_stb <= 1'b0;
			summed_memory_address <= '0;
			block_address <= '0;
		end
		else
		begin
			mem_stb <= host_stb;
			if (host_stb)
			begin
				summed_memory_address <= next_sum;
				case (addr_mode)
					HWBO_ADDR_SIXTEEN_BYTE_BLOCK_ADDRESSING:
						block_address <= next_sum << HWBO_SIXTEEN_BYTE_BLOCK_ADDRESSING_SHIFT;
					HWBO_ADDR_BY8:
						block_address <= next_sum << HWBO_BY8_SHIFT;
					default:
						block_address <= next_sum;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			bytes_per_host_byte <= HWBO_BYTES_NORMAL;
			latch_bytes <= HWBO_LATCH_NORMAL;
			byte_write_mask <= 16'h0000;
		end
		else
		begin
			if (enh16)
				bytes_per_host_byte <= HWBO_BYTES_ENH;
			else if (write_mode_extensions[HWBO_B_EXT_WR])
				bytes_per_host_byte <= HWBO_BYTES_EXT;
			else
				bytes_per_host_byte <= HWBO_BYTES_NORMAL;
			latch_bytes <= write_mode_extensions[HWBO_B_LATCH8]
				? HWBO_LATCH_WIDE : HWBO_LATCH_NORMAL;
			for (int i = 0; i < 8; i++)
			begin
				if (enh16)
				begin
					byte_write_mask[2*i] <= plane_write_mask[i];
					byte_write_mask[2*i+1] <= plane_write_mask[i];
				end
				else
				begin
					byte_write_mask[i] <= plane_write_mask[i];
					byte_write_mask[i+8] <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	chk_first_sel: assert property (
		host_stb && !write_mode_extensions[0]
		&& !write_mode_extensions[5]
		&& memory_map_select != HWBO_MAP_64K
		|=> summed_memory_address[19:12] == 8'($past(host_addr[16:12])
		+ $past(bank_offset_first)))
		else $error("first offset sum");
	chk_second_sel: assert property (
		host_stb && write_mode_extensions[0] && host_addr[15]
		&& !write_mode_extensions[5]
		|=> summed_memory_address[19:12] == 8'($past(host_addr[14:12])
		+ $past(bank_offset_second)))
		else $error("second offset sum");
	// the sum is cut to ten bits, so a carry past bit 21 must vanish
	chk_gran16_sum: assert property (
		host_stb && write_mode_extensions[5]
		&& !write_mode_extensions[0]
		&& memory_map_select != HWBO_MAP_64K
		|=> summed_memory_address[21:12] == 10'($past(host_addr[16:12]))
		+ 10'({$past(bank_offset_first), 2'b00}))
		else $error("16K sum");
	chk_wrap_low: assert property (
		host_stb |=> summed_memory_address[11:0] == $past(host_addr[11:0]))
		else $error("low bits pass");
	chk_map64_b15: assert property (
		host_stb && memory_map_select == HWBO_MAP_64K
		&& !write_mode_extensions[0] && !write_mode_extensions[5]
		|=> summed_memory_address[19:12] == 8'({1'b0,
		$past(host_addr[15:12])} + $past(bank_offset_first)))
		else $error("64K mask");
	chk_nibble_clr: assert property (
		$fell(write_mode_extensions[2]) && !reg_wr
		|=> set_reset_value[7:4] == 4'h0 && set_reset_enable[7:4] == 4'h0)
		else $error("nibble clear");
	chk_sixteen_byte_block_addressing_shift: assert property (
		host_stb && enh16
		|=> block_address == 22'(summed_memory_address << 4))
		else $error("sixteen_byte_block_addressing shift");
	chk_by8_shift: assert property (
		host_stb && eight_byte_block_addressing
		|=> block_address == 22'(summed_memory_address << 3))
		else $error("by8 shift");
	chk_packed_addr: assert property (
		host_stb && !enh16 && !eight_byte_block_addressing
		|=> block_address == summed_memory_address)
		else $error("packed address");
	chk_bytes_enh: assert property (
		enh16 |=> bytes_per_host_byte == HWBO_BYTES_ENH)
		else $error("16 bytes");
	chk_bytes_ext: assert property (
		write_mode_extensions[2] && !enh16
		|=> bytes_per_host_byte == HWBO_BYTES_EXT)
		else $error("8 bytes");
	chk_mask_dbl: assert property (
		enh16 |=> byte_write_mask[1:0] == {2{$past(plane_write_mask[0])}}
		&& byte_write_mask[15:14] == {2{$past(plane_write_mask[7])}})
		else $error("mask doubling");
	chk_latch_w: assert property (
		write_mode_extensions[3] |=> latch_bytes == HWBO_LATCH_WIDE)
		else $error("latch width");
	chk_latch_n: assert property (
		!write_mode_extensions[3] |=> latch_bytes == HWBO_LATCH_NORMAL)
		else $error("latch normal");
	chk_mode45: assert property (
		enh_mode_active |-> write_mode_extensions[4]
		&& write_mode_extensions[2] && color_ext_enable
		&& (write_mode_sel == HWBO_WMODE_4 || write_mode_sel == HWBO_WMODE_5))
		else $error("mode");
	chk_page_ign: assert property (
		write_mode_extensions[5] |-> !page_select_used)
		else $error("page select");
	chk_page_4k: assert property (
		!write_mode_extensions[5] |-> page_select_used
		== extended_sequencer_mode) else $error("page select 4K");
	chk_mem_stb: assert property (host_stb |=> mem_stb)
		else $error("memory strobe");

	cov_second: cover property (host_stb && sel_second);
	cov_gran16: cover property (host_stb && write_mode_extensions[5]);
	cov_sixteen_byte_block_addressing: cover property (host_stb && enh16);
	cov_clear: cover property ($fell(write_mode_extensions[2]));
endmodule
`default_nettype wire

// *** verif/hwbo_host_model.sv ***
/*
 * Host bus model: issues one host cycle per request pulse.
 * Assumes requests come from the bench on sys_clk, at most one per cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module hwbo_host_model
	import hwbo_pkg::*;
(
	// clock
	input wire logic sys_clk,
	// request from the bench
	input wire logic go,
	input wire logic [HWBO_HA_W-1:0] go_addr,
	// host cycle
	output logic host_stb,
	output logic [HWBO_HA_W-1:0] host_addr
);
	initial host_stb = 1'b0;
	initial host_addr = '0;
	// idle address flips every cycle so a stale value is never read
	always @(posedge sys_clk)
	begin
		host_stb <= go;
		host_addr <= go ? go_addr : ~host_addr;
	end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
/*
 * Bench for the host window bank offset block.
 * Assumes the host bus model drives host cycles; registers are indexed.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import hwbo_pkg::*;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_index = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [1:0] map_sel = 2'h0;
	logic [2:0] wmode = HWBO_WMODE_4;
	logic seq_page = 1'b1;
	logic go = 1'b0;
	logic [16:0] go_addr = 17'h00000;
	logic host_stb;
	logic [16:0] host_addr;
	logic mem_stb;
	logic [21:0] sum_a, blk_a;
	logic [15:0] bmask;
	logic [4:0] bytes;
	logic [3:0] latch;
	logic color, enh, page;
	logic [7:0] srv, sre;
	int bad_count = 0;
	int checks = 0;
	always #2.5 sys_clk = ~sys_clk;
	hwbo_host_model hwbo_host_model_i (.sys_clk(sys_clk), .go(go),
		.go_addr(go_addr), .host_stb(host_stb), .host_addr(host_addr));
	hwbo_top hwbo_top_i (.sys_clk(sys_clk), .srst(srst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_index(reg_index), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .memory_map_select(map_sel),
		.extended_sequencer_mode(seq_page), .write_mode_sel(wmode),
		.plane_write_mask(8'h5A), .host_stb(host_stb),
		.host_addr(host_addr), .mem_stb(mem_stb),
		.summed_memory_address(sum_a), .block_address(blk_a),
		.byte_write_mask(bmask), .bytes_per_host_byte(bytes),
		.latch_bytes(latch), .color_ext_enable(color),
		.enh_mode_active(enh), .page_select_used(page),
		.set_reset_value(srv), .set_reset_enable(sre));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1)
		begin
			bad_count++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_index <= i;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_index <= i;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata === e, "register read");
	endtask
	function automatic logic [21:0] exp_sum(input logic [16:0] a,
		input logic [7:0] w, o1, o2, input logic m);
		logic [4:0] x;
		logic [7:0] o;
		logic [9:0] s;
		x = a[16:12];
		if (m || w[0])
			x[4] = 1'b0;
		if (w[0])
			x[3] = 1'b0;
		o = (w[0] && a[15]) ? o2 : o1;
		if (w[5])
			s = {5'h00, x} + {o, 2'h0};
		else
		begin
			s = {5'h00, x} + {2'h0, o};
			s[9:8] = 2'h0;
		end
		return {s, a[11:0]};
	endfunction
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rd(HWBO_IDX_OFS_FIRST, 8'h00);
		rd(HWBO_IDX_OFS_SECOND, 8'h00);
		rd(HWBO_IDX_WR_EXT, 8'h00);
		chk(bytes === 5'h01 && latch === 4'h4, "reset modes");
		chk(mem_stb === 1'b0, "reset strobe");
	endtask
	task automatic t_regs();
		wr(HWBO_IDX_OFS_FIRST, 8'hA5);
		wr(HWBO_IDX_OFS_SECOND, 8'h5A);
		wr(HWBO_IDX_WR_EXT, 8'hED);
		wr(8'h3C, 8'h77);
		rd(HWBO_IDX_OFS_FIRST, 8'hA5);
		rd(HWBO_IDX_OFS_SECOND, 8'h5A);
		rd(HWBO_IDX_WR_EXT, 8'h2D);
		rd(8'h3C, 8'h00);
	endtask
	task automatic t_case(input logic [7:0] w, input logic m,
		input logic [16:0] a, input logic [7:0] o1, o2);
		logic [21:0] s, b;
		logic [15:0] dm;
		logic e;
		e = w[4] & w[2];
		s = exp_sum(a, w, o1, o2, m);
		b = e ? s << 4 : (w[1] ? s << 3 : s);
		dm = e ? 16'h33CC : 16'h005A;
		wr(HWBO_IDX_WR_EXT, w);
		wr(HWBO_IDX_OFS_FIRST, o1);
		wr(HWBO_IDX_OFS_SECOND, o2);
		map_sel <= m ? HWBO_MAP_64K : 2'h0;
		@(posedge sys_clk);
		go <= 1'b1;
		go_addr <= a;
		@(posedge sys_clk);
		go <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk(mem_stb === 1'b1, "memory strobe");
		chk(sum_a === s, "summed address");
		chk(blk_a === b, "block address");
		chk(bmask === dm, "mask");
		chk(bytes === (e ? 5'h10 : (w[2] ? 5'h08 : 5'h01)), "bytes");
		chk(latch === (w[3] ? 4'h8 : 4'h4), "latch");
		chk(color === e && enh === e, "enhanced");
		chk(page === !w[5], "page select");
	endtask
	task automatic t_sr();
		wr(HWBO_IDX_WR_EXT, 8'h04);
		wr(HWBO_IDX_SET_RESET, 8'hFF);
		wr(HWBO_IDX_SR_ENABLE, 8'hF3);
		wr(HWBO_IDX_WR_EXT, 8'h00);
		rd(HWBO_IDX_SET_RESET, 8'h0F);
		rd(HWBO_IDX_SR_ENABLE, 8'h03);
		chk(srv === 8'h0F && sre === 8'h03, "set reset ports");
	endtask
	task automatic t_modes();
		wr(HWBO_IDX_WR_EXT, 8'h14);
		wmode <= 3'h0;
		seq_page <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk(enh === 1'b0 && color === 1'b1, "mode gate");
		chk(page === 1'b0, "page select off");
		@(posedge sys_clk);
		wmode <= HWBO_WMODE_5;
		seq_page <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk(enh === 1'b1 && page === 1'b1, "mode five");
	endtask
	initial
	begin
		#20000;
		bad_count++;
		wrap_up();
	end
	initial
	begin
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		t_reset();
		t_regs();
		t_case(8'h00, 1'b0, 17'h12345, 8'hA5, 8'h00);
		t_case(8'h00, 1'b1, 17'h1F123, 8'h10, 8'h40);
		t_case(8'h00, 1'b0, 17'h1F000, 8'hFF, 8'h00);
		t_case(8'h01, 1'b1, 17'h09ABC, 8'h10, 8'h40);
		t_case(8'h01, 1'b1, 17'h01ABC, 8'h10, 8'h40);
		t_case(8'h20, 1'b0, 17'h1F000, 8'hFF, 8'h00);
		t_case(8'h26, 1'b0, 17'h00001, 8'h01, 8'h00);
		t_case(8'h1C, 1'b0, 17'h00010, 8'h02, 8'h00);
		t_case(8'h10, 1'b0, 17'h00003, 8'h00, 8'h00);
		t_modes();
		t_sr();
		wrap_up();
	end
endmodule
`default_nettype wire
